// ==== rtl/uth_params.svh ====
// Constants for the untraceable command handler
// Contract
// RULE1: Execute only while tag is secured
// RULE2: Frame fields, order and opcode fixed
// RULE3: Ignore the spare flag bit entirely
// RULE4: Item field: hide bit plus word count
// RULE5: Protocol word size follows item length
// RULE6: Identity field: none, from 20h, all
// RULE7: Hidden memory absent while tag open
// RULE8: Hidden access answers memory overrun error
// RULE9: Range field: normal, toggle, reduced
// RULE10: Toggled range reverts after power loss
// RULE11: Outside secured: no reply, state moves
// RULE12: Secured and executable: update, header reply
// RULE13: Reserved codes, bad handle, CRC refused
`ifndef UTH_PARAMS_SVH
`define UTH_PARAMS_SVH
// Frame layout, bit 61 is the first bit on air
`define UTH_FRAME_W     62
`define UTH_OPCODE      16'hE200
`define UTH_F_OPC_MSB   61
`define UTH_F_OPC_LSB   46
`define UTH_F_SPR_MSB   45
`define UTH_F_SPR_LSB   44
`define UTH_F_ITM_MSB   42
`define UTH_F_ITM_LSB   37
`define UTH_F_ID_MSB    36
`define UTH_F_ID_LSB    35
`define UTH_F_USR       34
`define UTH_F_RNG_MSB   33
`define UTH_F_RNG_LSB   32
`define UTH_F_HDL_MSB   31
`define UTH_F_HDL_LSB   16
// Field codes
`define UTH_ID_NONE     2'h0
`define UTH_ID_SOME     2'h1
`define UTH_ID_ALL      2'h2
`define UTH_ID_RSVD     2'h3
`define UTH_RNG_NORMAL  2'h0
`define UTH_RNG_TOGGLE  2'h1
`define UTH_RNG_REDUCED 2'h2
`define UTH_RNG_RSVD    2'h3
// CRC-16 preset and good residue
`define UTH_CRC_PRESET  16'hFFFF
`define UTH_CRC_POLY    16'h1021
`define UTH_CRC_RESID   16'h1D0F
// Memory banks and hiding boundaries (word addresses)
`define UTH_BANK_ITEM   2'h1
`define UTH_BANK_ID     2'h2
`define UTH_BANK_USER   2'h3
`define UTH_ITEM_BASE   8'h02
`define UTH_ID_BOUND    8'h20
// Register byte offsets
`define UTH_REG_CTRL    8'h00
`define UTH_REG_SET     8'h04
`define UTH_REG_STAT    8'h08
`define UTH_REG_CNT     8'h0C
// Settings register layout and reset values
`define UTH_S_LEN_MSB   4
`define UTH_S_HIDE      5
`define UTH_S_ID_MSB    7
`define UTH_S_ID_LSB    6
`define UTH_S_USR       8
`define UTH_S_RNG       9
`define UTH_RST_LEN     5'h06
`define UTH_RST_CTRL    1'h1
`endif

// ==== rtl/uth_pkg.sv ====
// Types shared by the untraceable command handler
package uth_pkg;
  // Handler sequencer, one-hot
  typedef enum logic [2:0] {
    UTH_IDLE  = 3'h1,
    UTH_EVAL  = 3'h2,
    UTH_REPLY = 3'h4
  } uth_fsm_t;
  // Tag protocol states, one-hot, driven by the tag state machine
  typedef enum logic [6:0] {
    UTH_TS_READY   = 7'h01,
    UTH_TS_ARB     = 7'h02,
    UTH_TS_REPLY   = 7'h04,
    UTH_TS_ACK     = 7'h08,
    UTH_TS_OPEN    = 7'h10,
    UTH_TS_SECURED = 7'h20,
    UTH_TS_KILLED  = 7'h40
  } uth_tag_t;
endpackage : uth_pkg

// ==== rtl/uth_crc16.sv ====
// CRC-16 residue check over a whole received frame
`include "uth_params.svh"
module uth_crc16 import uth_pkg::*; #(
  parameter int W = `UTH_FRAME_W
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] data_i,
  output logic              ok_o
);
  logic [15:0] crc;   // Running remainder
  logic        fb;    // Feedback bit

  // Whole frame in one cycle; depth is W stages of xor, fine at 100 MHz
  always_comb begin
    crc = `UTH_CRC_PRESET;
    fb  = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb  = crc[15] ^ data_i[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? `UTH_CRC_POLY : 16'h0000);
    end
  end

  // Registered verdict, valid one cycle after the data
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ok_o <= 1'b0;
    end else begin
      ok_o <= (crc == `UTH_CRC_RESID);
    end
  end
endmodule : uth_crc16

// ==== rtl/uth_hide_check.sv ====
// Access filter that turns hidden memory into a memory overrun
`include "uth_params.svh"
module uth_hide_check import uth_pkg::*; #(
  parameter int AW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          acc_valid_i,
  input  wire logic [1:0]    acc_bank_i,
  input  wire logic [AW-1:0] acc_addr_i,
  input  wire logic          tag_open_i,
  input  wire logic          item_hide_i,
  input  wire logic [4:0]    item_len_i,
  input  wire logic [1:0]    id_hide_i,
  input  wire logic          user_hide_i,
  output logic               acc_done_o,
  output logic               acc_overrun_o
);
  logic [AW-1:0] item_end;  // First word past the item code
  logic          hidden;    // Target lies in hidden memory

  assign item_end = AW'({3'h0, item_len_i}) + AW'(`UTH_ITEM_BASE);

  // Hiding only matters in the open state; secured sees everything
  always_comb begin
    hidden = 1'b0;
    if (tag_open_i) begin  // [RULE7]
      unique case (acc_bank_i)
        `UTH_BANK_ITEM: hidden = item_hide_i && (acc_addr_i >= item_end);
        `UTH_BANK_ID: begin  // [RULE6]
          hidden = (id_hide_i == `UTH_ID_ALL) ||
                   ((id_hide_i == `UTH_ID_SOME) &&
                    (acc_addr_i >= AW'(`UTH_ID_BOUND)));
        end
        `UTH_BANK_USER: hidden = user_hide_i;
        default:        hidden = 1'b0;
      endcase
    end
  end

  // One-cycle verdict per access
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_done_o    <= 1'b0;
      acc_overrun_o <= 1'b0;
    end else begin
      acc_done_o    <= acc_valid_i;
      acc_overrun_o <= acc_valid_i && hidden;  // [RULE8]
    end
  end
endmodule : uth_hide_check

// ==== rtl/uth_handler.sv ====
// Untraceable command decoder, executor and APB register file
`include "uth_params.svh"
module uth_handler import uth_pkg::*; #(
  parameter int AW = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Decoded frame from the air interface receiver
  input  wire logic                    frame_valid_i,
  input  wire logic [`UTH_FRAME_W-1:0] frame_data_i,
  output logic                         frame_ready_o,
  input  wire logic [15:0]             session_handle_i,
  input  wire logic [6:0]              tag_state_i,
  output logic                         state_upd_o,
  output logic [6:0]                   next_tag_state_o,
  output logic                         reply_hdr_o,
  // Power supervisor pin, asynchronous
  input  wire logic                    power_loss_i,
  // Memory access filter
  input  wire logic                    acc_valid_i,
  input  wire logic [1:0]              acc_bank_i,
  input  wire logic [AW-1:0]           acc_addr_i,
  output logic                         acc_done_o,
  output logic                         acc_overrun_o,
  // Live settings toward the modulator and the inventory logic
  output logic [4:0]                   pcw_len_o,
  output logic                         range_reduced_o
);
  uth_fsm_t                  fsm;          // Sequencer state
  logic [`UTH_FRAME_W-1:0]   frame_q;      // Captured frame
  logic [15:0]               handle_q;     // Handle at capture
  uth_tag_t                  tag_q;        // Tag state at capture
  logic                      crc_ok;       // Residue check verdict
  logic                      cmd_en;       // Software enable
  logic [4:0]                item_len;     // Backscattered item words
  logic                      item_hide;    // Hide above item code
  logic [1:0]                id_hide;      // Identity hiding code
  logic                      user_hide;    // User bank hidden
  logic                      range_nv;     // Stored range, 1 = reduced
  logic                      toggled;      // Volatile range flip
  logic                      pl_meta;      // Power-loss sync stage 1
  logic                      pl_sync;      // Power-loss sync stage 2
  logic [15:0]               n_exec;       // Executed commands
  logic [15:0]               n_refused;    // Refused commands
  logic                      opc_hit;      // Opcode matches
  logic                      executable;   // Frame passes every check
  logic                      apply;        // Settings change this cycle
  logic                      set_wr;       // Software writes settings
  logic                      mapped;       // Address hits a register

  // Field views; the flag bit between spare and item is never read
  logic [5:0] f_item;                                   // [RULE3]
  logic [1:0] f_id;
  logic       f_user;
  logic [1:0] f_rng;
  assign f_item = frame_q[`UTH_F_ITM_MSB:`UTH_F_ITM_LSB];  // [RULE2]
  assign f_id   = frame_q[`UTH_F_ID_MSB:`UTH_F_ID_LSB];
  assign f_user = frame_q[`UTH_F_USR];
  assign f_rng  = frame_q[`UTH_F_RNG_MSB:`UTH_F_RNG_LSB];

  // Residue check runs on the incoming frame, ready in EVAL
  uth_crc16 #(.W(`UTH_FRAME_W)) u_crc (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .data_i (frame_data_i),
    .ok_o   (crc_ok)
  );

  // Hidden memory filter for reads and writes from the reader
  uth_hide_check #(.AW(AW)) u_hide (
    .clk_i         (clk_i),
    .srst_i        (srst_i),
    .acc_valid_i   (acc_valid_i),
    .acc_bank_i    (acc_bank_i),
    .acc_addr_i    (acc_addr_i),
    .tag_open_i    (tag_state_i == UTH_TS_OPEN),
    .item_hide_i   (item_hide),
    .item_len_i    (item_len),
    .id_hide_i     (id_hide),
    .user_hide_i   (user_hide),
    .acc_done_o    (acc_done_o),
    .acc_overrun_o (acc_overrun_o)
  );

  // Power-loss pin is asynchronous; only pl_sync is read by logic
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pl_meta <= 1'b0;
      pl_sync <= 1'b0;
    end else begin
      pl_meta <= power_loss_i;
      pl_sync <= pl_meta;
    end
  end

  // Frames are accepted only while idle; others see ready low
  assign frame_ready_o = (fsm == UTH_IDLE);

  // Opcode match only; spare bits are checked in executable
  assign opc_hit = frame_q[`UTH_F_OPC_MSB:`UTH_F_OPC_LSB] == `UTH_OPCODE;

  // Reserved codes, a stale handle or a bad CRC make it unexecutable
  assign executable = opc_hit && crc_ok &&                       // [RULE13]
    (frame_q[`UTH_F_SPR_MSB:`UTH_F_SPR_LSB] == 2'h0) &&          // [RULE2]
    (f_id != `UTH_ID_RSVD) && (f_rng != `UTH_RNG_RSVD) &&
    (frame_q[`UTH_F_HDL_MSB:`UTH_F_HDL_LSB] == handle_q);

  // Settings change only from the secured state
  assign apply = (fsm == UTH_EVAL) && executable &&
                 (tag_q == UTH_TS_SECURED);                      // [RULE1]

  // Sequencer: capture, judge, then one reply cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fsm <= UTH_IDLE;
    end else begin
      unique case (fsm)
        UTH_IDLE:  if (frame_valid_i && cmd_en) fsm <= UTH_EVAL;
        UTH_EVAL:  fsm <= UTH_REPLY;
        UTH_REPLY: fsm <= UTH_IDLE;
        default:   fsm <= UTH_IDLE;
      endcase
    end
  end

  // Capture the frame with the handle and tag state it arrived under
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      frame_q  <= '0;
      handle_q <= 16'h0000;
      tag_q    <= UTH_TS_READY;
    end else if (fsm == UTH_IDLE && frame_valid_i) begin
      frame_q  <= frame_data_i;
      handle_q <= session_handle_i;
      tag_q    <= uth_tag_t'(tag_state_i);
    end
  end

  // Answer toward the tag state machine and the modulator
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_upd_o      <= 1'b0;
      next_tag_state_o <= UTH_TS_READY;
      reply_hdr_o      <= 1'b0;
    end else begin
      state_upd_o <= (fsm == UTH_EVAL) && opc_hit;
      reply_hdr_o <= apply;                                      // [RULE12]
      if (fsm == UTH_EVAL) begin
        // Not secured: silence, and the inventory states fall back
        unique case (tag_q)
          UTH_TS_ARB, UTH_TS_REPLY,
          UTH_TS_ACK: next_tag_state_o <= UTH_TS_ARB;            // [RULE11]
          default:    next_tag_state_o <= tag_q;
        endcase
      end
    end
  end

  // Software writes the stored settings, as the memory preload would
  assign set_wr = psel && penable && pwrite && (paddr == `UTH_REG_SET);

  // Hiding settings; a command in the same cycle wins over software
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      item_len  <= `UTH_RST_LEN;
      item_hide <= 1'b0;
      id_hide   <= `UTH_ID_NONE;
      user_hide <= 1'b0;
    end else if (apply) begin
      item_len  <= f_item[4:0];                                  // [RULE4]
      item_hide <= f_item[5];
      id_hide   <= f_id;                                         // [RULE6]
      user_hide <= f_user;                                       // [RULE7]
    end else if (set_wr) begin
      item_len  <= pwdata[`UTH_S_LEN_MSB:0];
      item_hide <= pwdata[`UTH_S_HIDE];
      id_hide   <= pwdata[`UTH_S_ID_MSB:`UTH_S_ID_LSB];
      user_hide <= pwdata[`UTH_S_USR];
    end
  end

  // Protocol control word size bits track the item length
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pcw_len_o <= `UTH_RST_LEN;
    end else begin
      pcw_len_o <= item_len;                                     // [RULE5]
    end
  end

  // Stored range plus a volatile flip that power loss discards
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      range_nv <= 1'b0;
      toggled  <= 1'b0;
    end else if (apply && f_rng != `UTH_RNG_TOGGLE) begin
      range_nv <= (f_rng == `UTH_RNG_REDUCED);                   // [RULE9]
      toggled  <= 1'b0;
    end else if (apply) begin
      toggled  <= ~toggled;                                      // [RULE9]
    end else begin
      // A preload during power loss must not be dropped
      if (pl_sync) begin
        toggled  <= 1'b0;                                        // [RULE10]
      end
      if (set_wr) begin
        range_nv <= pwdata[`UTH_S_RNG];
      end
    end
  end

  // Effective range seen by the modulator
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      range_reduced_o <= 1'b0;
    end else begin
      range_reduced_o <= range_nv ^ toggled;
    end
  end

  // Command statistics; counters wrap
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      n_exec    <= 16'h0000;
      n_refused <= 16'h0000;
    end else if (apply) begin
      n_exec    <= n_exec + 16'h0001;
    end else if (fsm == UTH_EVAL && opc_hit) begin
      n_refused <= n_refused + 16'h0001;
    end
  end

  // Control register: clearing the enable makes the handler deaf
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_en <= `UTH_RST_CTRL;
    end else if (psel && penable && pwrite && paddr == `UTH_REG_CTRL) begin
      cmd_en <= pwdata[0];
    end
  end

  // APB: no wait states, error for unmapped addresses
  always_comb begin
    unique case (paddr)
      `UTH_REG_CTRL, `UTH_REG_SET,
      `UTH_REG_STAT, `UTH_REG_CNT: mapped = 1'b1;
      default:                     mapped = 1'b0;
    endcase
  end
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;

  // Read data latched in the setup phase so it comes from a flop
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `UTH_REG_CTRL: prdata <= {31'h0000_0000, cmd_en};
        `UTH_REG_SET:  prdata <= {22'h00_0000, range_nv, user_hide,
                                  id_hide, item_hide, item_len};
        `UTH_REG_STAT: prdata <= {29'h0000_0000, (fsm != UTH_IDLE),
                                  toggled, range_nv ^ toggled};
        `UTH_REG_CNT:  prdata <= {n_refused, n_exec};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_no_apply_unsecured;
    (fsm == UTH_EVAL) && (tag_q != UTH_TS_SECURED) && !set_wr |=>
      $stable(item_len) && $stable(id_hide) && $stable(user_hide);
  endproperty
  a_no_apply_unsecured: assert property (p_no_apply_unsecured) // [RULE1]
    else $error("settings changed outside secured state");

  property p_fields;
    apply |-> (frame_q[`UTH_F_OPC_MSB:`UTH_F_OPC_LSB] == `UTH_OPCODE)
              && (frame_q[`UTH_F_SPR_MSB:`UTH_F_SPR_LSB] == 2'h0);
  endproperty
  a_fields: assert property (p_fields) // [RULE2]
    else $error("applied a frame with wrong opcode or spare bits");

  property p_item;
    apply |=> (item_len == $past(f_item[4:0])) &&
              (item_hide == $past(f_item[5]));
  endproperty
  a_item: assert property (p_item) // [RULE4]
    else $error("item code field not applied");

  property p_pcw;
    apply |=> ##1 (pcw_len_o == $past(f_item[4:0], 2));
  endproperty
  a_pcw: assert property (p_pcw) // [RULE5]
    else $error("protocol word size bits out of step");

  property p_id_all;
    acc_valid_i && (tag_state_i == UTH_TS_OPEN) &&
    (acc_bank_i == `UTH_BANK_ID) && (id_hide == `UTH_ID_ALL)
      |=> acc_overrun_o;
  endproperty
  a_id_all: assert property (p_id_all) // [RULE6]
    else $error("hidden identity bank answered without overrun");

  property p_secured_sees;
    acc_valid_i && (tag_state_i != UTH_TS_OPEN) |=> !acc_overrun_o;
  endproperty
  a_secured_sees: assert property (p_secured_sees) // [RULE7]
    else $error("overrun raised outside the open state");

  property p_toggle;
    apply && (f_rng == `UTH_RNG_TOGGLE) |=> ##1
      (range_reduced_o != $past(range_reduced_o, 1));
  endproperty
  a_toggle: assert property (p_toggle) // [RULE9]
    else $error("range toggle did not flip the range");

  property p_power_loss;
    pl_sync && !apply |=> !toggled;
  endproperty
  a_power_loss: assert property (p_power_loss) // [RULE10]
    else $error("toggled range survived a power loss");

  property p_fallback;
    (fsm == UTH_EVAL) && opc_hit && (tag_q == UTH_TS_ACK) |=>
      state_upd_o && !reply_hdr_o && (next_tag_state_o == UTH_TS_ARB);
  endproperty
  a_fallback: assert property (p_fallback) // [RULE11]
    else $error("acknowledged tag did not fall back silently");

  property p_reply;
    apply |=> reply_hdr_o && (next_tag_state_o == UTH_TS_SECURED);
  endproperty
  a_reply: assert property (p_reply) // [RULE12]
    else $error("executed command lacks header reply");

  property p_reserved;
    (fsm == UTH_EVAL) && (f_id == `UTH_ID_RSVD) |=> !reply_hdr_o;
  endproperty
  a_reserved: assert property (p_reserved) // [RULE13]
    else $error("reserved identity code was executed");

  c_apply:   cover property (apply);
  c_toggle:  cover property (apply && f_rng == `UTH_RNG_TOGGLE);
  c_refused: cover property ((fsm == UTH_EVAL) && opc_hit && !apply);
  c_overrun: cover property (acc_overrun_o);
endmodule : uth_handler

// ==== verif/uth_reader_model.sv ====
// Reader model that frames commands with CRC and hands them to the tag
`include "uth_params.svh"
module uth_reader_model (
  input  wire logic                    clk_i,
  input  wire logic                    frame_ready_i,
  output logic                         frame_valid_o,
  output logic [`UTH_FRAME_W-1:0]      frame_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle lines before the first frame
  initial begin
    frame_valid_o = 1'b0;
    frame_data_o  = '0;
  end

  // CRC-16 over the 46 leading bits, sent complemented
  function automatic logic [15:0] crc_of(input logic [45:0] d);
    logic [15:0] c;
    c = `UTH_CRC_PRESET;
    for (int i = 45; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `UTH_CRC_POLY : 16'h0000);
    end
    return ~c;
  endfunction : crc_of

  // Offer one frame, held until the tag shows ready at an edge
  task automatic send(input logic [45:0] body, input logic bad);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    frame_data_o  <= {body, crc_of(body) ^ {15'h0000, bad}};
    @(posedge clk_i);
    while (frame_ready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    // Released data must not keep looking like a frame
    frame_valid_o <= 1'b0;
    frame_data_o  <= ~frame_data_o;
  endtask : send
endmodule : uth_reader_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the untraceable command handler
`include "uth_params.svh"
module tb_top import uth_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] HDL = 16'h5A5A; // Session handle of the tag
  logic        clk_i = 1'b0;                // 100 MHz clock
  logic        srst_i = 1'b1;               // Held for 12 cycles
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        fvalid, fready, state_upd_o, reply_hdr_o;
  logic [61:0] fdata;
  logic [6:0]  tag_state = UTH_TS_READY;
  logic [6:0]  next_tag_state_o;
  logic        power_loss_i = 1'b0;
  logic        acc_valid = 1'b0;
  logic [1:0]  acc_bank = 2'h0;
  logic [7:0]  acc_addr = 8'h00;
  logic        acc_done_o, acc_overrun_o, range_reduced_o;
  logic [4:0]  pcw_len_o;
  logic [31:0] cnt_upd = 0, cnt_rep = 0, n_fail = 0, compares = 0;
  logic [31:0] cyc = 0;
  logic [6:0]  st_in [6] = '{UTH_TS_READY, UTH_TS_ARB, UTH_TS_REPLY,
                             UTH_TS_ACK, UTH_TS_OPEN, UTH_TS_KILLED};
  logic [6:0]  st_out [6] = '{UTH_TS_READY, UTH_TS_ARB, UTH_TS_ARB,
                              UTH_TS_ARB, UTH_TS_OPEN, UTH_TS_KILLED};
  logic [6:0]  last_st = 7'h00;             // Last reported next state

  always #5 clk_i = ~clk_i;

  uth_handler dut_u (.clk_i(clk_i), .srst_i(srst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_valid_i(fvalid), .frame_data_i(fdata), .frame_ready_o(fready),
    .session_handle_i(HDL), .tag_state_i(tag_state),
    .state_upd_o(state_upd_o), .next_tag_state_o(next_tag_state_o),
    .reply_hdr_o(reply_hdr_o), .power_loss_i(power_loss_i),
    .acc_valid_i(acc_valid), .acc_bank_i(acc_bank), .acc_addr_i(acc_addr),
    .acc_done_o(acc_done_o), .acc_overrun_o(acc_overrun_o),
    .pcw_len_o(pcw_len_o), .range_reduced_o(range_reduced_o));

  uth_reader_model rdr_u (.clk_i(clk_i), .frame_ready_i(fready),
    .frame_valid_o(fvalid), .frame_data_o(fdata));

  // Single-cycle pulses are counted in the cycle they stand
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (state_upd_o === 1'b1) begin
      cnt_upd <= cnt_upd + 1;
      last_st <= next_tag_state_o;
    end
    if (reply_hdr_o === 1'b1) begin
      cnt_rep <= cnt_rep + 1;
    end
    // A hang is cut short here
    if (cyc == 32'h0000_1388) begin
      // Blocking, so the verdict below already sees this failure
      n_fail++;
      $display("[ERR] cycles expected below %0d seen %0d", 5000, cyc);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares != 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd,
                     logic [31:0] e, logic err);
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    if (!wr) begin
      chk("prdata", e, prdata);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One memory access, verdict seen the cycle after it is taken
  task automatic acc(logic [1:0] bk, logic [7:0] ad, logic ov);
    @(posedge clk_i);
    acc_valid <= 1'b1;
    acc_bank  <= bk;
    acc_addr  <= ad;
    @(posedge clk_i);
    acc_valid <= 1'b0;
    #1;
    chk("acc_done", 32'h1, {31'h0, acc_done_o});
    chk("acc_overrun", {31'h0, ov}, {31'h0, acc_overrun_o});
  endtask : acc

  // Send a frame from a given tag state and check the pulses it gives
  task automatic frm(logic [6:0] st, logic [15:0] opc, logic [1:0] spr,
      logic [5:0] itm, logic [1:0] id, logic usr, logic [1:0] rng,
      logic [15:0] hdl, logic bad, logic eu, logic er, logic [6:0] es);
    logic [31:0] u0, r0;
    u0 = cnt_upd;
    r0 = cnt_rep;
    @(posedge clk_i);
    tag_state <= st;
    // Spare flag is always set: it must change nothing
    rdr_u.send({opc, spr, 1'b1, itm, id, usr, rng, hdl}, bad);
    repeat (4) @(posedge clk_i);
    chk("state_upd", u0 + eu, cnt_upd);
    chk("reply_hdr", r0 + er, cnt_rep);
    if (eu) begin
      chk("next_state", {25'h0, es}, {25'h0, last_st});
    end
  endtask : frm

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(0, `UTH_REG_CTRL, 0, 32'h0000_0001, 0);
    apb(0, `UTH_REG_SET, 0, 32'h0000_0006, 0);
    apb(0, 8'h10, 0, 32'h0000_0000, 1);
    apb(1, 8'h10, 32'hFFFF_FFFF, 0, 1);
    // Every state other than secured: no reply, no change
    for (int i = 0; i < 6; i++) begin
      frm(st_in[i], `UTH_OPCODE, 0, 6'h24, 1, 1, 2, HDL, 0,
          1, 0, st_out[i]);
    end
    apb(0, `UTH_REG_SET, 0, 32'h0000_0006, 0);
    chk("pcw_len", 32'h6, {27'h0, pcw_len_o});
    // Secured: hide above 4 words, identity from 20h, user, reduced
    frm(UTH_TS_SECURED, `UTH_OPCODE, 0, 6'h24, 1, 1, 2, HDL, 0,
        1, 1, UTH_TS_SECURED);
    apb(0, `UTH_REG_SET, 0, 32'h0000_0364, 0);
    chk("pcw_len", 32'h4, {27'h0, pcw_len_o});
    chk("range", 32'h1, {31'h0, range_reduced_o});
    tag_state <= UTH_TS_OPEN;
    acc(`UTH_BANK_ITEM, 8'h05, 0);
    acc(`UTH_BANK_ITEM, 8'h06, 1);
    acc(`UTH_BANK_ID, 8'h1F, 0);
    acc(`UTH_BANK_ID, 8'h20, 1);
    acc(`UTH_BANK_USER, 8'h00, 1);
    tag_state <= UTH_TS_SECURED;
    acc(`UTH_BANK_USER, 8'h00, 0);
    // Spare, identity, range, handle and CRC faults in turn
    for (int v = 0; v < 5; v++) begin
      frm(UTH_TS_SECURED, `UTH_OPCODE, (v == 0) ? 2'h1 : 2'h0, 6'h0A,
          (v == 1) ? 2'h3 : 2'h0, 0, (v == 2) ? 2'h3 : 2'h0,
          (v == 3) ? HDL ^ 16'h0001 : HDL, v == 4,
          1, 0, UTH_TS_SECURED);
    end
    apb(0, `UTH_REG_SET, 0, 32'h0000_0364, 0);
    // Toggle from reduced, hide whole identity bank, show item memory
    frm(UTH_TS_SECURED, `UTH_OPCODE, 0, 6'h04, 2, 0, 1, HDL, 0,
        1, 1, UTH_TS_SECURED);
    chk("range", 32'h0, {31'h0, range_reduced_o});
    apb(0, `UTH_REG_STAT, 0, 32'h0000_0002, 0);
    apb(0, `UTH_REG_SET, 0, 32'h0000_0284, 0);
    tag_state <= UTH_TS_OPEN;
    acc(`UTH_BANK_ID, 8'h00, 1);
    acc(`UTH_BANK_ITEM, 8'h0A, 0);
    acc(`UTH_BANK_USER, 8'h00, 0);
    // Power loss drops the toggle and restores the reduced range
    @(posedge clk_i);
    power_loss_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    power_loss_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("range", 32'h1, {31'h0, range_reduced_o});
    apb(0, `UTH_REG_STAT, 0, 32'h0000_0001, 0);
    frm(UTH_TS_SECURED, `UTH_OPCODE, 0, 6'h06, 0, 0, 0, HDL, 0,
        1, 1, UTH_TS_SECURED);
    chk("range", 32'h0, {31'h0, range_reduced_o});
    chk("pcw_len", 32'h6, {27'h0, pcw_len_o});
    apb(0, `UTH_REG_CNT, 0, 32'h000B_0003, 0);
    // A different opcode is not this command at all
    frm(UTH_TS_SECURED, 16'hE201, 0, 6'h06, 0, 0, 0, HDL, 0,
        0, 0, UTH_TS_SECURED);
    stop_test();
  end
endmodule : tb_top
